// ==== hw/ifd_defines.vh ====
// Second-word tag, opcode codes, flag masks, timing counts, register offsets and register widths of the decoder
`ifndef IFD_DEFINES_VH
`define IFD_DEFINES_VH
`define OSC_PER_CYCLE 4
`define CLK_PERIOD_NS 10
`define QCLK_NS 40
`define QCLK_DIV ((`QCLK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SECOND_WORD_TAG 4'hf
`define FLAG_C 5'h01
`define FLAG_DC 5'h02
`define FLAG_Z 5'h04
`define FLAG_OV 5'h08
`define FLAG_N 5'h10
`define FLAGS_ARITH 5'h1f
`define FLAGS_ZN 5'h14
`define FLAGS_Z 5'h04
`define OP_NOP 5'h00
`define OP_ADD 5'h01
`define OP_ADDC 5'h02
`define OP_INC 5'h03
`define OP_DEC 5'h04
`define OP_OR 5'h05
`define OP_AND 5'h06
`define OP_COM 5'h07
`define OP_MOV 5'h08
`define OP_CLR 5'h09
`define OP_CPEQ 5'h0a
`define OP_CPGT 5'h0b
`define OP_CPLT 5'h0c
`define OP_DECSZ 5'h0d
`define OP_DECSNZ 5'h0e
`define OP_INCSZ 5'h0f
`define OP_INCSNZ 5'h10
`define OP_BITCLR 5'h11
`define OP_BITSET 5'h12
`define OP_BITTOG 5'h13
`define OP_BTSC 5'h14
`define OP_BTSS 5'h15
`define OP_BRA 5'h16
`define OP_BCOND 5'h17
`define OP_CALL 5'h18
`define OP_GOTO 5'h19
`define OP_FILE_TO_FILE_MOVE 5'h1a
`define REG_INSTR 8'h00
`define REG_CONTROL 8'h04
`define REG_OPINFO 8'h08
`define REG_FILEADDR 8'h0c
`define REG_TARGET 8'h10
`define REG_OFFSET 8'h14
`define REG_PROGRAM_TABLE_POINTER 8'h18
`define REG_TBLLAT 8'h1c
`define REG_PROD 8'h20
`define REG_PCLATCH 8'h24
`define REG_STATUS 8'h28
`define PROGRAM_TABLE_POINTER_W 21
`define TARGET_W 20
`endif

// ==== hw/field_decode.v ====
// Combinational opcode and field decoder for one 16-bit instruction word
`timescale 1ns/1ps
`include "ifd_defines.vh"
module field_decode (
    input wire [15:0] word,
    output reg [4:0] op,
    output reg [4:0] flags,
    output reg is_skip,
    output reg is_two_word,
    output reg changes_pc,
    output wire dest_file,
    output wire bank_sel,
    output wire [7:0] faddr,
    output wire [2:0] bit_pos,
    output wire [7:0] literal,
    output wire fast_sel
);
    assign dest_file = word[9];
    assign bank_sel = word[8];
    assign faddr = word[7:0];
    assign bit_pos = word[11:9];
    assign literal = word[7:0];
    assign fast_sel = word[8];

    // Casez masks out d, a and operand bits so they never affect the opcode
    always @* begin
        op = `OP_NOP;
        flags = 5'h00;
        casez (word[15:8])
            8'b0010_01??: begin op = `OP_ADD; flags = `FLAGS_ARITH; end
            8'b0010_00??: begin op = `OP_ADDC; flags = `FLAGS_ARITH; end
            8'b0010_10??: begin op = `OP_INC; flags = `FLAGS_ARITH; end
            8'b0000_01??: begin op = `OP_DEC; flags = `FLAGS_ARITH; end
            8'b0001_00??: begin op = `OP_OR; flags = `FLAGS_ZN; end
            8'b0001_01??: begin op = `OP_AND; flags = `FLAGS_ZN; end
            8'b0001_11??: begin op = `OP_COM; flags = `FLAGS_ZN; end
            8'b0101_00??: begin op = `OP_MOV; flags = `FLAGS_ZN; end
            8'b0110_101?: begin op = `OP_CLR; flags = `FLAGS_Z; end
            8'b0110_001?: op = `OP_CPEQ;
            8'b0110_010?: op = `OP_CPGT;
            8'b0110_000?: op = `OP_CPLT;
            8'b0010_11??: op = `OP_DECSZ;
            8'b0100_11??: op = `OP_DECSNZ;
            8'b0011_11??: op = `OP_INCSZ;
            8'b0100_10??: op = `OP_INCSNZ;
            8'b1001_????: op = `OP_BITCLR;
            8'b1000_????: op = `OP_BITSET;
            8'b0111_????: op = `OP_BITTOG;
            8'b1011_????: op = `OP_BTSC;
            8'b1010_????: op = `OP_BTSS;
            8'b1101_0???: op = `OP_BRA;
            8'b1110_0???: op = `OP_BCOND;
            8'b1110_110?: op = `OP_CALL;
            8'b1110_1111: op = `OP_GOTO;
            8'b1100_????: op = `OP_FILE_TO_FILE_MOVE;
            default: op = `OP_NOP;
        endcase
    end

    always @* begin
        is_skip = (op == `OP_CPEQ) || (op == `OP_CPGT) || (op == `OP_CPLT) ||
            (op == `OP_DECSZ) || (op == `OP_DECSNZ) || (op == `OP_INCSZ) ||
            (op == `OP_INCSNZ) || (op == `OP_BTSC) || (op == `OP_BTSS);
        is_two_word = (op == `OP_CALL) || (op == `OP_GOTO) || (op == `OP_FILE_TO_FILE_MOVE);
        changes_pc = (op == `OP_BRA) || (op == `OP_CALL) || (op == `OP_GOTO);
    end
endmodule // field_decode

// ==== hw/instr_field_decoder.v ====
// Instruction field decoder with AHB-Lite register access and core-side decode outputs
//
// The AHB-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "ifd_defines.vh"
module instr_field_decoder (
    input wire sys_clk,
    input wire srst,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire hsel,
    input wire hready,
    input wire [31:0] hwdata,
    output reg [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    input wire [15:0] fetch_word,
    input wire fetch_valid,
    input wire skip_cond,
    output reg [4:0] exec_op_r,
    output reg [4:0] flag_mask_r,
    output reg dest_file_r,
    output reg bank_sel_r,
    output reg [11:0] src_addr_r,
    output reg [11:0] dst_addr_r,
    output reg [2:0] bit_pos_r,
    output reg [7:0] literal_r,
    output reg [19:0] target_r,
    output reg signed [10:0] rel_offset_r,
    output reg shadow_save_r,
    output reg [1:0] nop_cycles_r,
    output reg exec_valid_r,
    output wire cycle_tick
);
    // Software-visible state, plus the held first word and the tick divider
    reg [15:0] sw_instr_r;
    reg [`PROGRAM_TABLE_POINTER_W-1:0] program_table_pointer_r;
    reg [7:0] program_table_latch_r;
    reg [7:0] multiply_result_high_r;
    reg [7:0] multiply_result_low_r;
    reg [7:0] pc_high_latch_r;
    reg [7:0] pc_upper_latch_r;
    reg [7:0] pc_low_byte_r;
    reg [6:0] idx_src_r;
    reg [6:0] idx_dst_r;
    reg use_sw_r;
    reg [15:0] first_word_r;
    reg pend_r;
    reg [1:0] qdiv_r;

    wire [15:0] cur_word = use_sw_r ? sw_instr_r : fetch_word;
    wire [4:0] op;
    wire [4:0] flags;
    wire is_skip;
    wire is_two_word;
    wire changes_pc;
    wire dest_file;
    wire bank_sel;
    wire [7:0] faddr;
    wire [2:0] bit_pos;
    wire [7:0] literal;
    wire fast_sel;

    field_decode u_dec (
        .word(cur_word),
        .op(op),
        .flags(flags),
        .is_skip(is_skip),
        .is_two_word(is_two_word),
        .changes_pc(changes_pc),
        .dest_file(dest_file),
        .bank_sel(bank_sel),
        .faddr(faddr),
        .bit_pos(bit_pos),
        .literal(literal),
        .fast_sel(fast_sel)
    );

    // Instruction cycle enable: one pulse per four oscillator periods
    assign cycle_tick = (qdiv_r == 2'd3);
    always @(posedge sys_clk) begin
        if (srst) begin
            qdiv_r <= 2'd0;
        end else begin
            qdiv_r <= qdiv_r + 2'd1;
        end
    end

    wire word_in = cycle_tick && (fetch_valid || use_sw_r);
    wire second_tag = (cur_word[15:12] == `SECOND_WORD_TAG);

    always @(posedge sys_clk) begin
        if (srst) begin
            exec_op_r <= `OP_NOP;
            flag_mask_r <= 5'h00;
            dest_file_r <= 1'b0;
            bank_sel_r <= 1'b0;
            src_addr_r <= 12'h000;
            dst_addr_r <= 12'h000;
            bit_pos_r <= 3'h0;
            literal_r <= 8'h00;
            target_r <= 20'h00000;
            rel_offset_r <= 11'h000;
            shadow_save_r <= 1'b0;
            nop_cycles_r <= 2'd0;
            exec_valid_r <= 1'b0;
            first_word_r <= 16'h0000;
            pend_r <= 1'b0;
        end else begin
            exec_valid_r <= 1'b0;
            if (word_in) begin
                if (pend_r) begin
                    pend_r <= 1'b0;
                    exec_valid_r <= 1'b1;
                    if (first_word_r[15:12] == 4'hc) begin
                        // Second word carries the 12-bit destination below 1111
                        dst_addr_r <= cur_word[11:0];
                    end else begin
                        target_r <= {cur_word[11:0], first_word_r[7:0]};
                    end
                end else if (is_two_word) begin
                    pend_r <= 1'b1;
                    first_word_r <= cur_word;
                    exec_op_r <= op;
                    flag_mask_r <= flags;
                    src_addr_r <= cur_word[11:0];
                    shadow_save_r <= (op == `OP_CALL) && fast_sel;
                    nop_cycles_r <= 2'd1;
                end else begin
                    exec_valid_r <= 1'b1;
                    // A stray second word decodes to nop in the decoder
                    exec_op_r <= second_tag ? `OP_NOP : op;
                    flag_mask_r <= second_tag ? 5'h00 : flags;
                    dest_file_r <= dest_file;
                    bank_sel_r <= bank_sel;
                    src_addr_r <= {4'h0, faddr};
                    bit_pos_r <= bit_pos;
                    literal_r <= literal;
                    shadow_save_r <= 1'b0;
                    if (op == `OP_BRA) begin
                        rel_offset_r <= cur_word[10:0];
                    end else begin
                        rel_offset_r <= {{3{cur_word[7]}}, cur_word[7:0]};
                    end
                    // A taken skip costs one more cycle, the same over a two-word instruction
                    if (is_skip && skip_cond) begin
                        nop_cycles_r <= 2'd1;
                    end else if (changes_pc) begin
                        nop_cycles_r <= 2'd1;
                    end else begin
                        nop_cycles_r <= 2'd0;
                    end
                end
            end
        end
    end

    // AHB-Lite slave: zero wait states, always OKAY
    reg [7:0] a_addr_r;
    reg a_wr_r;
    reg a_rd_r;
    wire a_valid = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always @(posedge sys_clk) begin
        if (srst) begin
            a_addr_r <= 8'h00;
            a_wr_r <= 1'b0;
            a_rd_r <= 1'b0;
        end else begin
            a_wr_r <= a_valid && hwrite;
            a_rd_r <= a_valid && !hwrite;
            if (a_valid) begin
                a_addr_r <= haddr[7:0];
            end
        end
    end

    always @(posedge sys_clk) begin
        if (srst) begin
            sw_instr_r <= 16'h0000;
            use_sw_r <= 1'b0;
            program_table_pointer_r <= {`PROGRAM_TABLE_POINTER_W{1'b0}};
            program_table_latch_r <= 8'h00;
            multiply_result_high_r <= 8'h00;
            multiply_result_low_r <= 8'h00;
            pc_high_latch_r <= 8'h00;
            pc_upper_latch_r <= 8'h00;
            pc_low_byte_r <= 8'h00;
            idx_src_r <= 7'h00;
            idx_dst_r <= 7'h00;
        end else if (a_wr_r) begin
            case (a_addr_r)
                `REG_INSTR: sw_instr_r <= hwdata[15:0];
                `REG_CONTROL: use_sw_r <= hwdata[0];
                `REG_OFFSET: begin
                    idx_src_r <= hwdata[6:0];
                    idx_dst_r <= hwdata[14:8];
                end
                `REG_PROGRAM_TABLE_POINTER: program_table_pointer_r <= hwdata[`PROGRAM_TABLE_POINTER_W-1:0];
                `REG_TBLLAT: program_table_latch_r <= hwdata[7:0];
                `REG_PROD: begin
                    multiply_result_low_r <= hwdata[7:0];
                    multiply_result_high_r <= hwdata[15:8];
                end
                `REG_PCLATCH: begin
                    // Only the low byte reaches the PC directly
                    pc_low_byte_r <= hwdata[7:0];
                    pc_high_latch_r <= hwdata[15:8];
                    pc_upper_latch_r <= hwdata[23:16];
                end
                default: begin
                end
            endcase
        end
    end

    always @(posedge sys_clk) begin
        if (srst) begin
            hrdata <= 32'h00000000;
        end else if (a_valid && !hwrite) begin
            case (haddr[7:0])
                `REG_INSTR: hrdata <= {16'h0000, sw_instr_r};
                `REG_CONTROL: hrdata <= {31'h00000000, use_sw_r};
                `REG_OPINFO: hrdata <= {17'h00000, nop_cycles_r, pend_r, exec_valid_r,
                    shadow_save_r, flag_mask_r, exec_op_r};
                `REG_FILEADDR: hrdata <= {dest_file_r, bank_sel_r, bit_pos_r, 3'h0,
                    dst_addr_r, src_addr_r};
                `REG_TARGET: hrdata <= {12'h000, target_r};
                `REG_OFFSET: hrdata <= {5'h00, rel_offset_r, 1'b0, idx_dst_r,
                    1'b0, idx_src_r};
                `REG_PROGRAM_TABLE_POINTER: hrdata <= {11'h000, program_table_pointer_r};
                `REG_TBLLAT: hrdata <= {24'h000000, program_table_latch_r};
                `REG_PROD: hrdata <= {16'h0000, multiply_result_high_r, multiply_result_low_r};
                `REG_PCLATCH: hrdata <= {8'h00, pc_upper_latch_r, pc_high_latch_r,
                    pc_low_byte_r};
                `REG_STATUS: hrdata <= {24'h000000, literal_r};
                default: hrdata <= 32'h00000000;
            endcase
        end
    end
endmodule // instr_field_decoder

// ==== tb/ifd_monitor.sv ====
// Concurrent checks on decode results and instruction timing of the field decoder
`timescale 1ns/1ps
`include "ifd_defines.vh"
module ifd_monitor (
    input wire sys_clk,
    input wire srst,
    input wire skip_cond,
    input wire cycle_tick,
    input wire exec_valid_r,
    input wire [4:0] exec_op_r,
    input wire [4:0] flag_mask_r,
    input wire [1:0] nop_cycles_r,
    input wire shadow_save_r
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    wire ev = exec_valid_r;
    wire skip_op = exec_op_r inside {[`OP_CPEQ:`OP_INCSNZ]};
    property p_arith_flags;
        ev && (exec_op_r inside {`OP_ADD, `OP_ADDC, `OP_INC, `OP_DEC}) |-> flag_mask_r == 5'h1f;
    endproperty
    a_arith_flags: assert property (p_arith_flags) else $error("arith flag mask");
    property p_logic_flags;
        ev && (exec_op_r inside {`OP_OR, `OP_AND, `OP_COM, `OP_MOV}) |-> flag_mask_r == 5'h14;
    endproperty
    a_logic_flags: assert property (p_logic_flags) else $error("logic flag mask");
    property p_clear_flags; ev && exec_op_r == `OP_CLR |-> flag_mask_r == 5'h04; endproperty
    a_clear_flags: assert property (p_clear_flags) else $error("clear flag mask");
    property p_skip_flags; ev && skip_op |-> flag_mask_r == 5'h00; endproperty
    a_skip_flags: assert property (p_skip_flags) else $error("skip op flags");
    property p_skip_cycles; ev && skip_op |-> nop_cycles_r == {1'b0, $past(skip_cond)}; endproperty
    a_skip_cycles: assert property (p_skip_cycles) else $error("skip nop count");
    property p_branch_cycles; ev && exec_op_r == `OP_BRA |-> nop_cycles_r == 2'd1; endproperty
    a_branch_cycles: assert property (p_branch_cycles) else $error("branch nop count");
    // Tick spacing is fixed at four clocks, one per four oscillator periods
    property p_tick_period; cycle_tick |=> !cycle_tick [*3] ##1 cycle_tick; endproperty
    a_tick_period: assert property (p_tick_period) else $error("tick spacing");
    property p_valid_cause; ev |-> $past(cycle_tick) && !$past(ev); endproperty
    a_valid_cause: assert property (p_valid_cause) else $error("decode without tick");
    property p_nop_clean;
        ev && exec_op_r == `OP_NOP |-> flag_mask_r == 5'h00 && nop_cycles_r == 2'd0 && !shadow_save_r;
    endproperty
    a_nop_clean: assert property (p_nop_clean) else $error("nop not clean");
    c_file_to_file_move: cover property (ev && exec_op_r == `OP_FILE_TO_FILE_MOVE);
    c_call_fast: cover property (ev && exec_op_r == `OP_CALL && shadow_save_r);
    c_skip_taken: cover property (ev && skip_op && nop_cycles_r == 2'd1);
endmodule // ifd_monitor
bind instr_field_decoder ifd_monitor ifd_monitor_i (.sys_clk(sys_clk), .srst(srst),
    .skip_cond(skip_cond), .cycle_tick(cycle_tick), .exec_valid_r(exec_valid_r),
    .exec_op_r(exec_op_r), .flag_mask_r(flag_mask_r), .nop_cycles_r(nop_cycles_r),
    .shadow_save_r(shadow_save_r));

// ==== tb/prog_mem_model.sv ====
// Program memory model handing queued instruction words to the decoder on its ticks
`timescale 1ns/1ps
module prog_mem_model (
    input wire sys_clk,
    input wire srst,
    input wire cycle_tick,
    input wire stall,
    output wire [15:0] fetch_word,
    output wire fetch_valid
);
    logic [15:0] mem [0:255];
    logic [7:0] rd_ptr = 8'h00;
    logic [7:0] wr_ptr = 8'h00;
    logic [15:0] junk_r = 16'h0000;
    // A word leaves only on a tick the decoder really takes
    always @(posedge sys_clk) begin
        junk_r <= {junk_r[14:0], ~junk_r[15]};
        if (srst) rd_ptr <= wr_ptr;
        else if (cycle_tick && fetch_valid) rd_ptr <= rd_ptr + 8'h01;
    end
    // While stalled or empty the word lines move every cycle, so stale data never matches
    assign fetch_valid = !stall && rd_ptr != wr_ptr;
    assign fetch_word = fetch_valid ? mem[rd_ptr] : junk_r;
    task push(input logic [15:0] w);
        mem[wr_ptr] = w;
        wr_ptr = wr_ptr + 8'h01;
    endtask
endmodule // prog_mem_model

// ==== tb/instr_field_decoder_tb.sv ====
// Self-checking bench for the instruction field decoder
`timescale 1ns/1ps
`include "ifd_defines.vh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fail_count++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
module instr_field_decoder_tb;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, v;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0, skip_cond = 1'b0, stall = 1'b0, sk, d, a, s;
    logic [2:0] hsize = 3'b010, b;
    logic [7:0] f, k8;
    logic [11:0] k12;
    logic [15:0] w;
    wire hsel = 1'b1;
    wire [31:0] hrdata;
    wire hreadyout, hresp, hready, fetch_valid, dest_file_r, bank_sel_r, shadow_save_r;
    wire exec_valid_r, cycle_tick;
    wire [15:0] fetch_word;
    wire [4:0] exec_op_r, flag_mask_r;
    wire [11:0] src_addr_r, dst_addr_r;
    wire [2:0] bit_pos_r;
    wire [19:0] target_r;
    wire [7:0] literal_r;
    wire signed [10:0] rel_offset_r;
    wire [1:0] nop_cycles_r;
    int fail_count = 0, n_tests = 0, cycles = 0;
    logic [6:0] byte_pre [16] = '{7'h12, 7'h10, 7'h14, 7'h02, 7'h08, 7'h0a, 7'h0e, 7'h28,
        7'h16, 7'h26, 7'h1e, 7'h24, 7'h35, 7'h31, 7'h32, 7'h30};
    logic [4:0] byte_op [16] = '{`OP_ADD, `OP_ADDC, `OP_INC, `OP_DEC, `OP_OR, `OP_AND, `OP_COM,
        `OP_MOV, `OP_DECSZ, `OP_DECSNZ, `OP_INCSZ, `OP_INCSNZ, `OP_CLR, `OP_CPEQ, `OP_CPGT,
        `OP_CPLT};
    logic [3:0] bit_pre [5] = '{4'h9, 4'h8, 4'h7, 4'hb, 4'ha};
    logic [4:0] bit_op [5] = '{`OP_BITCLR, `OP_BITSET, `OP_BITTOG, `OP_BTSC, `OP_BTSS};
    logic [7:0] reg_adr [5] = '{`REG_PROGRAM_TABLE_POINTER, `REG_TBLLAT, `REG_PROD, `REG_OFFSET,
        `REG_PCLATCH};
    logic [31:0] reg_msk [5] = '{32'h001fffff, 32'h000000ff, 32'h0000ffff, 32'h00007f7f,
        32'h00ffffff};
    logic [15:0] nop_w [4] = '{16'hf000, 16'hfabc, 16'hffff, 16'h0000};
    assign hready = hreadyout;
    always #5 sys_clk = ~sys_clk;
    instr_field_decoder instr_field_decoder_i (.sys_clk(sys_clk), .srst(srst), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hsel(hsel), .hready(hready),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .fetch_word(fetch_word), .fetch_valid(fetch_valid), .skip_cond(skip_cond),
        .exec_op_r(exec_op_r), .flag_mask_r(flag_mask_r), .dest_file_r(dest_file_r),
        .bank_sel_r(bank_sel_r), .src_addr_r(src_addr_r), .dst_addr_r(dst_addr_r),
        .bit_pos_r(bit_pos_r), .literal_r(literal_r), .target_r(target_r),
        .rel_offset_r(rel_offset_r), .shadow_save_r(shadow_save_r),
        .nop_cycles_r(nop_cycles_r), .exec_valid_r(exec_valid_r), .cycle_tick(cycle_tick));
    prog_mem_model prog_mem_model_i (.sys_clk(sys_clk), .srst(srst), .cycle_tick(cycle_tick),
        .stall(stall), .fetch_word(fetch_word), .fetch_valid(fetch_valid));
    function automatic logic [4:0] exp_flags(input int i);
        if (i < 4) return 5'h1f;
        if (i < 8) return 5'h14;
        return (i == 12) ? 5'h04 : 5'h00;
    endfunction
    function automatic logic exp_skip(input int i, input logic c);
        return ((i >= 8 && i < 12) || i > 12) && c;
    endfunction
    task summarize;
        if (fail_count == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            summarize();
        end
    end
    task automatic bus(input logic wr, input logic [7:0] ad, input logic [31:0] dat);
        @(posedge sys_clk);
        haddr <= {24'h0, ad};
        hwrite <= wr;
        htrans <= 2'b10;
        do @(posedge sys_clk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= dat;
        do @(posedge sys_clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    // Memory stalls at random so words reach the decoder on uneven ticks
    task automatic issue(input logic [15:0] w1, w2, input bit two);
        int n;
        @(posedge sys_clk);
        sk = 1'($urandom);
        skip_cond <= sk;
        @(negedge sys_clk);
        prog_mem_model_i.push(w1);
        if (two) prog_mem_model_i.push(w2);
        for (n = 0; n < 80 && exec_valid_r !== 1'b1; n++) begin
            @(posedge sys_clk);
            stall <= ($urandom % 4) == 0;
        end
        `CHK(exec_valid_r, 1'b1)
    endtask
    initial begin
        void'($urandom(32'h2d79));
        repeat (6) @(posedge sys_clk);
        srst <= 1'b0;
        foreach (reg_adr[i]) begin
            bus(0, reg_adr[i], 0);
            `CHK(rd, 32'h0)
            for (int p = 0; p < 2; p++) begin
                v = p ? $urandom : 32'hffffffff;
                bus(1, reg_adr[i], v);
                bus(0, reg_adr[i], 0);
                `CHK(rd, v & reg_msk[i])
            end
        end
        bus(1, 8'h40, 32'hffffffff);
        bus(0, 8'h40, 0);
        `CHK(rd, 32'h0)
        repeat (3) for (int i = 0; i < 16; i++) begin
            {d, a, f} = 10'($urandom);
            w = {byte_pre[i][6:1], (i < 12) ? d : byte_pre[i][0], a, f};
            issue(w, 0, 0);
            `CHK(exec_op_r, byte_op[i])
            `CHK(flag_mask_r, exp_flags(i))
            `CHK({bank_sel_r, src_addr_r}, {a, 4'h0, f})
            if (i < 12) `CHK(dest_file_r, d)
            `CHK(nop_cycles_r, {1'b0, exp_skip(i, sk)})
        end
        foreach (nop_w[i]) begin
            issue(nop_w[i], 0, 0);
            `CHK({exec_op_r, flag_mask_r}, {`OP_NOP, 5'h00})
        end
        for (int r = 0; r < 5; r++) begin
            {k8, k12, s} = (r == 0) ? 21'h100801 : 21'($urandom);
            issue({7'h76, s, k8}, {4'hf, k12}, 1);
            `CHK({exec_op_r, target_r}, {`OP_CALL, k12, k8})
            `CHK(shadow_save_r, s)
            issue({8'hef, k8}, {4'hf, k12}, 1);
            `CHK({exec_op_r, target_r, shadow_save_r}, {`OP_GOTO, k12, k8, 1'b0})
            issue({4'hc, k12}, {4'hf, ~k12}, 1);
            `CHK({exec_op_r, src_addr_r, dst_addr_r}, {`OP_FILE_TO_FILE_MOVE, k12, ~k12})
            issue({5'h1a, k12[10:0]}, 0, 0);
            `CHK({exec_op_r, rel_offset_r}, {`OP_BRA, k12[10:0]})
            issue({8'he2, k8}, 0, 0);
            `CHK({exec_op_r, rel_offset_r}, {`OP_BCOND, {3{k8[7]}}, k8})
            `CHK(literal_r, k8)
            foreach (bit_pre[j]) begin
                b = 3'($urandom);
                issue({bit_pre[j], b, s, k8}, 0, 0);
                `CHK({exec_op_r, bit_pos_r, bank_sel_r}, {bit_op[j], b, s})
            end
        end
        bus(1, `REG_INSTR, 32'h2412);
        bus(1, `REG_CONTROL, 32'h1);
        repeat (8) @(posedge sys_clk);
        bus(0, `REG_OPINFO, 0);
        `CHK(rd[9:0], {5'h1f, `OP_ADD})
        summarize();
    end
endmodule // instr_field_decoder_tb
